/* logic/cbt_map.svh */
// Register offsets, field positions, reset values and timing counts
// Assumes a 32-bit classic Wishbone slave; byte addresses, one word each
`ifndef CBT_MAP_SVH
`define CBT_MAP_SVH
`define CBT_ADR_FBP0     8'h00
`define CBT_ADR_FBP7     8'h1C
`define CBT_ADR_MASK_SELECT_0    8'h20
`define CBT_ADR_MASK_SELECT_3    8'h2C
`define CBT_ADR_BRC1     8'h30
`define CBT_ADR_BRC2     8'h34
`define CBT_ADR_BRC3     8'h38
`define CBT_ADR_PINC     8'h3C
`define CBT_ADR_MODE     8'h40
`define CBT_ADR_STAT     8'h44
`define CBT_RST_FBP01    8'h00
`define CBT_RST_FBP1     8'h11
`define CBT_RST_FBP2     8'h11
`define CBT_RST_MASK_SELECT_0    8'h50
`define CBT_RST_MASK_SELECT_1    8'h05
`define CBT_RST_ZERO     8'h00
`define CBT_RST_MODE     8'h01
`define CBT_BRC3_MASK    8'hC7
`define CBT_PINC_MASK    8'h30
`define CBT_BIT_PH2FREE  7
`define CBT_BIT_SAMPLE   6
`define CBT_BIT_WAKEDIS  7
`define CBT_BIT_WAKEFIL  6
`define CBT_BIT_DRVHI    5
`define CBT_BIT_CAPEN    4
`define CBT_IPT_TQ       4'h2
`define CBT_PTR_RESV     4'h8
`endif

/* logic/cbt_pkg.sv */
// Types shared by the bit timing and filter routing block
// Assumes the constants of cbt_map.svh
package cbt_pkg;
   typedef struct packed {
      logic [1:0] jump_width_tq;    // 0..3 means 1..4 quanta
      logic [7:0] quantum_osc;      // Oscillator periods per quantum, 2..128
      logic [3:0] prop_tq;
      logic [3:0] phase1_tq;
      logic [3:0] phase2_tq;
      logic       triple_sample_sel;
   } cbt_timing_s;
   typedef struct packed {
      logic wake_enable;
      logic wake_line_filter_sel;
   } cbt_wake_s;
   typedef enum logic [1:0] {
      CBT_MASK0 = 2'h0,
      CBT_MASK1 = 2'h1,
      CBT_MASK_F15 = 2'h2,
      CBT_MASK_NONE = 2'h3
   } cbt_mask_e;
   typedef enum logic [1:0] {
      CBT_IDLE = 2'b01,
      CBT_ACK  = 2'b10
   } cbt_bus_e;
endpackage

/* logic/cbt_top.sv */
// Bit timing, filter routing and pin control registers of a CAN controller
// Assumes a classic Wishbone master on ref_clk and a transceiver on the pins
// Overview of operation
// (RQ1) Each filter has a 4-bit pointer: 0,1 dedicated buffers; 2..7 programmable; rest reserved
// (RQ2) Each filter has 2-bit mask select: mask0, mask1, filter 15, none
// (RQ3) Jump width equals field value plus one quanta
// (RQ4) Quantum equals two times (prescaler plus one) oscillator periods
// (RQ5) Free phase 2 length equals field value plus one quanta
// (RQ6) Select bit clear: phase 2 is max of phase 1 and processing time
// (RQ7) Wake disable bit turns wake detection off; select bit adds line filter
// (RQ8) Drive-high bit set drives recessive high, else tri-state
// (RQ9) Capture enable routes receive signal to capture unit, else the pin
// (RQ10) Software should set drive-high bit on differential buses
// (RQ11) Pointer and mask select registers written only in configuration mode
// (RQ12) Phase 1 and propagation equal field plus one; sample bit picks three or one
// (RQ13) Bit rate registers written only in configuration mode
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "cbt_map.svh"
module cbt_top (
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic                 tx_bit,
   input  wire logic                 rx_msg_event,
   input  wire logic                 capture_input_pin,
   output logic                      bus_tx_pin_o,
   output logic                      bus_tx_pin_oe,
   output logic                      capture_out,
   output logic [63:0]               filter_buffer_ptr,
   output logic [31:0]               filter_mask_sel,
   output logic [15:0]               filter_ptr_reserved,
   output cbt_pkg::cbt_timing_s      timing,
   output cbt_pkg::cbt_wake_s        wake
);
   import cbt_pkg::*;

   // Register state
   logic [7:0]  fbp [0:7];
   logic [7:0]  msel [0:3];
   logic [7:0]  brc1;
   logic [7:0]  brc2;
   logic [7:0]  brc3;
   logic [7:0]  pinc;
   logic [7:0]  mode;
   logic [7:0]  next_fbp [0:7];
   logic [7:0]  next_msel [0:3];
   logic [7:0]  next_brc1;
   logic [7:0]  next_brc2;
   logic [7:0]  next_brc3;
   logic [7:0]  next_pinc;
   logic [7:0]  next_mode;
   logic [31:0] next_dat;
   logic        next_ack;
   cbt_bus_e    bus_st;
   cbt_bus_e    next_bus_st;
   logic        cfg_mode;
   logic        wr_go;
   // Capture path state
   logic [2:0]  cap_sync;
   logic        cap_seen;
   logic        next_cap_seen;

   // Configuration mode gates routing and bit rate writes
   assign cfg_mode = mode[0];
   assign wr_go    = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & (bus_st == CBT_IDLE);

   // Bus slave and register writes
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         next_fbp[i] = fbp[i];
      end
      for (int i = 0; i < 4; i++) begin
         next_msel[i] = msel[i];
      end
      next_brc1   = brc1;
      next_brc2   = brc2;
      next_brc3   = brc3;
      next_pinc   = pinc;
      next_mode   = mode;
      next_ack    = 1'b0;
      next_bus_st = CBT_IDLE;
      case (bus_st)
         CBT_IDLE: begin
            if (wb_cyc_i && wb_stb_i) begin
               next_ack    = 1'b1;
               next_bus_st = CBT_ACK;
               if (wr_go && cfg_mode) begin
                  if (wb_adr_i <= `CBT_ADR_FBP7 && wb_adr_i[1:0] == 2'b00) begin
                     next_fbp[wb_adr_i[4:2]] = wb_dat_i[7:0]; // [RQ1] [RQ11]
                  end
                  if (wb_adr_i >= `CBT_ADR_MASK_SELECT_0 && wb_adr_i <= `CBT_ADR_MASK_SELECT_3
                      && wb_adr_i[1:0] == 2'b00) begin
                     next_msel[wb_adr_i[3:2]] = wb_dat_i[7:0]; // [RQ2] [RQ11]
                  end
                  if (wb_adr_i == `CBT_ADR_BRC1) next_brc1 = wb_dat_i[7:0]; // [RQ13]
                  if (wb_adr_i == `CBT_ADR_BRC2) next_brc2 = wb_dat_i[7:0]; // [RQ13]
                  if (wb_adr_i == `CBT_ADR_BRC3) begin
                     next_brc3 = wb_dat_i[7:0] & `CBT_BRC3_MASK; // [RQ13]
                  end
               end
               if (wr_go && wb_adr_i == `CBT_ADR_PINC) begin
                  next_pinc = wb_dat_i[7:0] & `CBT_PINC_MASK;
               end
               if (wr_go && wb_adr_i == `CBT_ADR_MODE) next_mode = {7'h00, wb_dat_i[0]};
            end
         end
         CBT_ACK: begin
            next_bus_st = CBT_IDLE; // Ack drops the cycle after it rose
         end
         default: begin
            next_bus_st = CBT_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fbp[0]  <= `CBT_RST_FBP01;
         fbp[1]  <= `CBT_RST_FBP1;
         fbp[2]  <= `CBT_RST_FBP2;
         for (int i = 3; i < 8; i++) begin
            fbp[i] <= `CBT_RST_ZERO;
         end
         msel[0] <= `CBT_RST_MASK_SELECT_0;
         msel[1] <= `CBT_RST_MASK_SELECT_1;
         msel[2] <= `CBT_RST_ZERO;
         msel[3] <= `CBT_RST_ZERO;
         brc1    <= `CBT_RST_ZERO;
         brc2    <= `CBT_RST_ZERO;
         brc3    <= `CBT_RST_ZERO;
         pinc    <= `CBT_RST_ZERO;
         mode    <= `CBT_RST_MODE;
         wb_ack_o <= 1'b0;
         bus_st   <= CBT_IDLE;
      end else begin
         fbp      <= next_fbp;
         msel     <= next_msel;
         brc1     <= next_brc1;
         brc2     <= next_brc2;
         brc3     <= next_brc3;
         pinc     <= next_pinc;
         mode     <= next_mode;
         wb_ack_o <= next_ack;
         bus_st   <= next_bus_st;
      end
   end

   // Read data: chosen as the request is taken, shown with ack
   always_comb begin
      next_dat = 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_we_i && bus_st == CBT_IDLE) begin
         if (wb_adr_i <= `CBT_ADR_FBP7 && wb_adr_i[1:0] == 2'b00) begin
            next_dat = {24'h00_0000, fbp[wb_adr_i[4:2]]};
         end else if (wb_adr_i >= `CBT_ADR_MASK_SELECT_0 && wb_adr_i <= `CBT_ADR_MASK_SELECT_3
                      && wb_adr_i[1:0] == 2'b00) begin
            next_dat = {24'h00_0000, msel[wb_adr_i[3:2]]};
         end else begin
            case (wb_adr_i)
               `CBT_ADR_BRC1: next_dat = {24'h00_0000, brc1};
               `CBT_ADR_BRC2: next_dat = {24'h00_0000, brc2};
               `CBT_ADR_BRC3: next_dat = {24'h00_0000, brc3};
               `CBT_ADR_PINC: next_dat = {24'h00_0000, pinc};
               `CBT_ADR_MODE: next_dat = {24'h00_0000, mode};
               `CBT_ADR_STAT: next_dat = {8'h00, filter_ptr_reserved,
                                          7'h00, cap_seen}; // Reserved flags in 23:8, capture-seen in bit 0
               default:       next_dat = 32'h0000_0000;
            endcase
         end
      end
   end

   // Read data register; zero between answers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_dat_o <= next_dat;
      end
   end

   // Decoded timing, routing and pin controls
   cbt_timing_s next_timing;
   cbt_wake_s   next_wake;
   logic [63:0] next_ptr;
   logic [31:0] next_msk;
   logic [15:0] next_resv;
   logic [3:0]  ph1;

   // Pin and capture next values
   logic        next_tx_o;
   logic        next_tx_oe;
   logic        next_cap;
   logic [2:0]  next_cap_sync;
   logic        cap_level;
   logic        next_cap_level;
   logic        cap_clear;

   // Bit timing fields turned into quanta counts
   always_comb begin
      ph1 = {1'b0, brc2[5:3]} + 4'h1;                     // [RQ12]
      next_timing.jump_width_tq     = brc1[7:6];          // [RQ3]
      next_timing.quantum_osc       = {1'b0, brc1[5:0], 1'b0} + 8'h02; // [RQ4]
      next_timing.prop_tq           = {1'b0, brc2[2:0]} + 4'h1;  // [RQ12]
      next_timing.phase1_tq         = ph1;
      next_timing.triple_sample_sel = brc2[`CBT_BIT_SAMPLE]; // [RQ12]
      if (brc2[`CBT_BIT_PH2FREE]) begin
         next_timing.phase2_tq = {1'b0, brc3[2:0]} + 4'h1;   // [RQ5]
      end else begin
         next_timing.phase2_tq = (ph1 > `CBT_IPT_TQ) ? ph1 : `CBT_IPT_TQ; // [RQ6]
      end
   end

   // Timing register; zero only while reset is held
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         timing <= '0;
      end else begin
         timing <= next_timing;
      end
   end

   // Wake-up controls and per-filter routing fields
   always_comb begin
      next_wake.wake_enable          = ~brc3[`CBT_BIT_WAKEDIS]; // [RQ7]
      next_wake.wake_line_filter_sel = brc3[`CBT_BIT_WAKEFIL];  // [RQ7]
      // Filter f owns nibble f%2 of pointer word f/2
      for (int f = 0; f < 16; f++) begin
         next_ptr[f*4 +: 4] = fbp[f/2][(f%2)*4 +: 4];     // [RQ1]
         next_resv[f]       = fbp[f/2][(f%2)*4 + 3];      // [RQ1]
         next_msk[f*2 +: 2] = msel[f/4][(f%4)*2 +: 2];    // [RQ2]
      end
   end

   // Routing and wake registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wake                <= '0;
         filter_buffer_ptr   <= '0;
         filter_mask_sel     <= '0;
         filter_ptr_reserved <= '0;
      end else begin
         wake                <= next_wake;
         filter_buffer_ptr   <= next_ptr;
         filter_mask_sel     <= next_msk;
         filter_ptr_reserved <= next_resv;
      end
   end

   // Dominant drives low; recessive drives high or floats
   always_comb begin
      next_tx_o  = tx_bit;
      next_tx_oe = ~tx_bit | pinc[`CBT_BIT_DRVHI];         // [RQ8]
   end

   // Transmit pin registers; released and recessive while in reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bus_tx_pin_o  <= 1'b1;
         bus_tx_pin_oe <= 1'b0;
      end else begin
         bus_tx_pin_o  <= next_tx_o;
         bus_tx_pin_oe <= next_tx_oe;
      end
   end

   // Software clear of the capture-seen flag
   assign cap_clear = wr_go && wb_adr_i == `CBT_ADR_STAT && wb_dat_i[0];

   // Pin synchroniser, capture source select and sticky capture-seen flag
   always_comb begin
      next_cap_sync  = {cap_sync[1:0], capture_input_pin};
      // Level moves only once the second and third stages agree
      next_cap_level = (cap_sync[1] == cap_sync[2]) ? cap_sync[2] : cap_level;
      next_cap       = pinc[`CBT_BIT_CAPEN] ? rx_msg_event : next_cap_level; // [RQ9]
      next_cap_seen  = cap_seen | next_cap;
      if (cap_clear) begin
         next_cap_seen = next_cap; // Set wins over a same-cycle clear
      end
   end

   // Capture registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         capture_out <= 1'b0;
         cap_sync    <= 3'h0;
         cap_level   <= 1'b0;
         cap_seen    <= 1'b0;
      end else begin
         capture_out <= next_cap;
         cap_sync    <= next_cap_sync;
         cap_level   <= next_cap_level;
         cap_seen    <= next_cap_seen;
      end
   end
endmodule

/* sim/cbt_top_chk.sv */
// Port checker for the bit timing and filter routing block
// Assumes a single ref_clk domain with rst as its asynchronous reset
`timescale 1ns/1ps
module cbt_top_chk import cbt_pkg::*; (
   input logic        ref_clk,
   input logic        rst,
   input logic        wb_cyc_i,
   input logic        wb_stb_i,
   input logic        wb_we_i,
   input logic [7:0]  wb_adr_i,
   input logic [3:0]  wb_sel_i,
   input logic [31:0] wb_dat_i,
   input logic [31:0] wb_dat_o,
   input logic        wb_ack_o,
   input logic        tx_bit,
   input logic        bus_tx_pin_o,
   input logic        bus_tx_pin_oe,
   input logic [63:0] filter_buffer_ptr,
   input logic [31:0] filter_mask_sel,
   input logic [15:0] filter_ptr_reserved,
   input cbt_timing_s timing
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic        cfg;
   logic        wr;
   logic [15:0] resv;
   // Shadow of the configuration-mode bit
   assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
   always_ff @(posedge ref_clk or posedge rst)
      if (rst) cfg <= 1'b1;
      else if (wr && wb_adr_i == 8'h40) cfg <= wb_dat_i[0];
   // Expected reserved flags: top bit of each pointer
   always_comb
      for (int f = 0; f < 16; f++) resv[f] = filter_buffer_ptr[4*f+3];
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after request");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   AST_RD_HIGH: assert property (wb_ack_o |-> wb_dat_o[31:24] == 8'h00
      && (wb_adr_i == 8'h44 || wb_dat_o[23:8] == 16'h0000))
      else $error("read data upper bits not zero");
   AST_DOMINANT: assert property (!tx_bit |=> bus_tx_pin_oe && !bus_tx_pin_o)
      else $error("dominant bit not driven low");
   AST_TX_FOLLOW: assert property (!$past(rst) |-> bus_tx_pin_o == $past(tx_bit))
      else $error("pin level does not follow bit");
   AST_QUANTUM: assert property (!$past(rst) |-> !timing.quantum_osc[0]
      && timing.quantum_osc != 8'h00 && timing.quantum_osc <= 8'h80)
      else $error("quantum not an even count from 2 to 128");
   AST_RESERVED: assert property (!$past(rst) |-> filter_ptr_reserved == resv)
      else $error("reserved pointer flags wrong");
   AST_LOCK_RATE: assert property (wr && !cfg && wb_adr_i inside {8'h30, 8'h34, 8'h38}
      |=> $stable(timing) [*3]) else $error("rate register changed outside configuration");
   AST_LOCK_FILT: assert property (wr && !cfg && wb_adr_i < 8'h30
      |=> ($stable(filter_buffer_ptr) && $stable(filter_mask_sel)) [*3])
      else $error("routing changed outside configuration");
endmodule
bind cbt_top cbt_top_chk i_cbt_top_chk (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_bit, .bus_tx_pin_o,
   .bus_tx_pin_oe, .filter_buffer_ptr, .filter_mask_sel, .filter_ptr_reserved, .timing);

/* sim/cbt_xcvr_model.sv */
// Transceiver stand-in that resolves the transmit pin onto the bus
// Assumes the transmit input carries a pull-up, so it sits recessive when undriven
`timescale 1ns/1ps
module cbt_xcvr_model (
   input  logic txd,
   input  logic txd_oe,
   output logic bus_level
);
   // Undriven pin floats up to the recessive level
   assign bus_level = txd_oe ? txd : 1'b1;
endmodule

/* sim/tb.sv */
// Register-level testbench for the bit timing and filter routing block
// Assumes the Wishbone offsets of cbt_map.svh and a transceiver model on the pin
`timescale 1ns/1ps
module tb import cbt_pkg::*;;
   logic        ref_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
   logic        tx_bit = 1, rx_ev = 0, cap_pin = 0, ack, oe, txo, cap_out, bus;
   logic [7:0]  adr = 0, q;
   logic [23:0] qh;
   logic [3:0]  sel = 0;
   logic [31:0] dat = 0, rdat, fmsk;
   logic [63:0] fptr;
   logic [15:0] fres;
   cbt_timing_s tim;
   cbt_wake_s   wk;
   int          n_fail = 0, samples_checked = 0;
   logic [7:0]  ra [6] = '{8'h04, 8'h08, 8'h20, 8'h24, 8'h3C, 8'h50};
   logic [7:0]  rv [6] = '{8'h11, 8'h11, 8'h50, 8'h05, 8'h00, 8'h00};
   always #5 ref_clk = ~ref_clk;
   cbt_top i_cbt_top (.ref_clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .tx_bit, .rx_msg_event(rx_ev), .capture_input_pin(cap_pin), .bus_tx_pin_o(txo),
      .bus_tx_pin_oe(oe), .capture_out(cap_out), .filter_buffer_ptr(fptr),
      .filter_mask_sel(fmsk), .filter_ptr_reserved(fres), .timing(tim), .wake(wk));
   cbt_xcvr_model i_cbt_xcvr_model (.txd(txo), .txd_oe(oe), .bus_level(bus));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   // One classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge ref_clk);
      {cyc, stb, we, adr, sel} <= {1'b1, 1'b1, w, a, 4'hF};
      dat <= {24'h00_0000, d};
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      {qh, q} = rdat;
      {cyc, stb} <= 2'b00;
      if (n >= 20) begin
         n_fail++;
         end_of_test();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(q, e);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic end_of_test();
      $display("checked %0d, failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Cut a hang short
   initial begin
      tick(20000);
      n_fail++;
      end_of_test();
   end
   // Main sequence
   initial begin
      tick(6);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
      chk({fptr[15:8], fmsk[15:8], 6'h00, oe, bus}, 32'h0011_0501);
      $display("test 1 done");
      for (int i = 0; i < 4; i++) begin
         wr(8'h30, {i[1:0], 6'(i * 21)});
         tick(2);
         chk(tim.jump_width_tq, i);
         chk(tim.quantum_osc, (i * 21 + 1) * 2);
      end
      wr(8'h38, 8'hFF);
      rd(8'h38, 8'hC7);
      for (int i = 0; i < 8; i++) begin
         wr(8'h34, {1'b0, i[0], i[2:0], 3'(7 - i)});
         tick(2);
         chk({tim.phase1_tq, tim.prop_tq, 3'h0, tim.triple_sample_sel},
             {4'(i + 1), 4'(8 - i), 3'h0, i[0]});
         chk(tim.phase2_tq, (i < 1) ? 2 : i + 1);
      end
      chk(wk, 2'b01);
      wr(8'h34, 8'h80);
      tick(2);
      chk(tim.phase2_tq, 8);
      wr(8'h38, 8'h00);
      tick(2);
      chk({tim.phase2_tq, wk}, 6'h06);
      $display("test 2 done");
      for (int i = 0; i < 8; i++) begin
         wr(8'h00, {4'(2 * i + 1), 4'(2 * i)});
         tick(2);
         chk({fptr[7:0], fres[1:0]}, {4'(2 * i + 1), 4'(2 * i), {2{i > 3}}});
      end
      wr(8'h2C, 8'hE4);
      tick(2);
      chk(fmsk[31:24], 8'hE4);
      $display("test 3 done");
      wr(8'h40, 8'h00);
      wr(8'h30, 8'h3F);
      wr(8'h00, 8'h55);
      wr(8'h2C, 8'h00);
      wr(8'h3C, 8'h20);
      rd(8'h30, 8'hFF);
      rd(8'h00, 8'hFE);
      rd(8'h2C, 8'hE4);
      rd(8'h3C, 8'h20);
      chk({oe, bus}, 2'b11);
      tx_bit <= 1'b0;
      tick(2);
      chk({oe, bus}, 2'b10);
      tx_bit <= 1'b1;
      $display("test 4 done");
      wr(8'h3C, 8'h10);
      rx_ev <= 1'b1;
      tick(2);
      chk({oe, bus, cap_out}, 3'b011);
      {rx_ev, cap_pin} <= 2'b01;
      tick(2);
      chk(cap_out, 1'b0);
      wr(8'h3C, 8'h00);
      tick(6);
      chk(cap_out, 1'b1);
      rd(8'h44, 8'h01);
      chk(qh, 24'h00_0003);
      cap_pin <= 1'b0;
      tick(6);
      chk(cap_out, 1'b0);
      wr(8'h44, 8'h01);
      rd(8'h44, 8'h00);
      wr(8'h40, 8'h01);
      $display("test 5 done");
      end_of_test();
   end
endmodule
